// [design/ste_core.sv]
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - data read gives receive buffer, write after status read fills transmit
// - master starts transfer when byte written
// - unread receive byte kept, new one dropped
// - free shifter takes queued byte, sets tx empty
// - sample one edge, shift next; eight clocks
// - transfer end fills receive buffer, sets full
// - phase one waiting byte starts next transfer back to back
// - MSB first unless lsb first selected
// - polarity and phase give four clock formats
// - phase one select leads by half clock
// - phase zero select trails by half clock
// - phase one slave drives on select, edge shifts
// - phase zero slave presents first bit at select
// - flags with enables raise one interrupt
// - mode fault on low select in master config
// - mode fault drops master mode and drivers
// - fault flag clears by status read, ctrl write
// - tx empty clears by status read, data write
// - rx full clears by status read, data read
// - idle master moves written byte within two cycles
module ste_core (
  input wire logic clock,
  input wire logic rst,
  input wire ste_pkg::ste_apb_req_t apbReq,
  output ste_pkg::ste_apb_rsp_t apbRsp,
  input wire ste_pkg::ste_pins_in_t pinsIn,
  output ste_pkg::ste_pins_out_t pinsOut,
  output logic irq
);
  import ste_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    ste_state_t fsm;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] div;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic [7:0] txSh;
    logic [7:0] rxSh;
    logic [7:0] halfCnt;
    logic [4:0] edgeCnt;
    logic txEmpty;
    logic rxFull;
    logic mode_fault_flag;
    logic txArm;
    logic rxArm;
    logic modfArm;
    logic sclkLvl;
    logic sclkPrev;
    logic [31:0] prdata;
    logic pslverr;
  } ste_core_st_t;

  ste_core_st_t st_q;
  ste_core_st_t st_d;
  ste_pins_in_t pinSync;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  ste_sync #(
    .WIDTH(STE_SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn(pinsIn),
    .syncOut(pinSync)
  );

  // ==========================================================
  // Decoded configuration
  // ==========================================================
  logic master;
  logic clk_polarity_sel;
  logic clk_phase_sel;
  logic lsbFirst;
  logic ssLow;
  logic txBit;
  logic misoQuiet;

  // Control bits and the current outgoing bit.
  assign master = st_q.ctrl1[STE_C1_MASTER_SEL];
  assign clk_polarity_sel = st_q.ctrl1[STE_C1_CLK_POLARITY_SEL];
  assign clk_phase_sel = st_q.ctrl1[STE_C1_CLK_PHASE_SEL];
  assign lsbFirst = st_q.ctrl1[STE_C1_LSBF];
  assign ssLow = ~pinSync.ssN;
  assign txBit = lsbFirst ? st_q.txSh[0] : st_q.txSh[7];
  assign misoQuiet = st_q.mode_fault_flag & ~st_q.ctrl2[STE_C2_BIDIR];

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic access;
    logic wr;
    logic rd;
    logic tick;
    logic edgeEv;
    logic [4:0] edgeNum;
    logic sampleEv;
    logic shiftEv;
    logic inBit;
    logic [7:0] rxNext;
    logic complete;
    logic rxClear;
    logic txLoad;
    logic [7:0] rdVal;
    logic hit;
    access = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    tick = 1'b0;
    edgeEv = 1'b0;
    edgeNum = 5'h00;
    sampleEv = 1'b0;
    shiftEv = 1'b0;
    inBit = 1'b0;
    rxNext = 8'h00;
    complete = 1'b0;
    rxClear = 1'b0;
    txLoad = 1'b0;
    rdVal = 8'h00;
    hit = 1'b1;
    st_d = st_q;
    st_d.sclkPrev = pinSync.sclk;

    // Bus access phase and the flag arming sequences.
    access = apbReq.psel & apbReq.penable;
    wr = access & apbReq.pwrite;
    rd = access & ~apbReq.pwrite;
    if (wr && apbReq.paddr == STE_ADDR_CTRL1) begin
      st_d.ctrl1 = apbReq.pwdata[7:0];
      if (st_q.modfArm) begin
        st_d.mode_fault_flag = 1'b0;
        st_d.modfArm = 1'b0;
      end
    end
    if (wr && apbReq.paddr == STE_ADDR_CTRL2) begin
      st_d.ctrl2 = apbReq.pwdata[7:0];
    end
    if (wr && apbReq.paddr == STE_ADDR_DIV) begin
      st_d.div = apbReq.pwdata[7:0];
    end
    if (rd && apbReq.paddr == STE_ADDR_STATUS) begin
      st_d.txArm = st_q.prdata[STE_ST_TXEMPTY];
      st_d.rxArm = st_q.prdata[STE_ST_RXFULL];
      st_d.modfArm = st_q.prdata[STE_ST_MODE_FAULT_FLAG];
    end
    if (wr && apbReq.paddr == STE_ADDR_DATA && st_q.txArm) begin
      st_d.txBuf = apbReq.pwdata[7:0];
      st_d.txEmpty = 1'b0;
      st_d.txArm = 1'b0;
    end
    if (rd && apbReq.paddr == STE_ADDR_DATA && st_q.rxArm) begin
      rxClear = 1'b1;
      st_d.rxArm = 1'b0;
    end

    // Half period timer for master clock generation.
    tick = st_q.halfCnt <= STE_MIN_HALF;
    if (tick) begin
      st_d.halfCnt = (st_q.div < STE_MIN_HALF) ? STE_MIN_HALF : st_q.div;
    end else begin
      st_d.halfCnt = st_q.halfCnt - STE_MIN_HALF;
    end

    // Serial clock edges: own timer as master, pin edges as slave.
    if (master) begin
      edgeEv = tick && (st_q.fsm == STE_LEAD || st_q.fsm == STE_RUN);
      inBit = pinSync.miso;
    end else begin
      edgeEv = st_q.fsm == STE_SRUN && pinSync.sclk != st_q.sclkPrev;
      inBit = pinSync.mosi;
    end
    edgeNum = st_q.edgeCnt + STE_FIRST_EDGE;
    // Phase zero samples odd edges; phase one samples even edges.
    sampleEv = edgeEv & (clk_phase_sel ^ edgeNum[0]);
    shiftEv = edgeEv & (clk_phase_sel ? (edgeNum[0] && edgeNum != STE_FIRST_EDGE)
                             : ~edgeNum[0]);
    rxNext = lsbFirst ? {inBit, st_q.rxSh[7:1]}
                      : {st_q.rxSh[6:0], inBit};
    if (sampleEv) begin
      st_d.rxSh = rxNext;
    end
    if (shiftEv) begin
      st_d.txSh = lsbFirst ? {1'b0, st_q.txSh[7:1]}
                           : {st_q.txSh[6:0], 1'b0};
    end
    if (edgeEv) begin
      st_d.edgeCnt = edgeNum;
      st_d.sclkLvl = ~st_q.sclkLvl;
    end

    // Transfer sequencing.
    case (st_q.fsm)
      STE_IDLE: begin
        st_d.sclkLvl = clk_polarity_sel;
        st_d.edgeCnt = 5'h00;
        if (master && !st_q.txEmpty) begin
          txLoad = 1'b1;
          st_d.fsm = STE_LEAD;
          st_d.halfCnt = st_q.div;
        end else if (!master && ssLow) begin
          txLoad = !st_q.txEmpty;
          st_d.fsm = STE_SRUN;
        end
      end
      STE_LEAD: begin
        if (tick) begin
          st_d.fsm = STE_RUN;
        end
      end
      STE_RUN: begin
        if (edgeEv && edgeNum == STE_LAST_EDGE) begin
          st_d.fsm = STE_TRAIL;
        end
      end
      STE_TRAIL: begin
        if (tick) begin
          complete = 1'b1;
          st_d.edgeCnt = 5'h00;
          if (clk_phase_sel && !st_q.txEmpty) begin
            txLoad = 1'b1;
            st_d.fsm = STE_LEAD;
          end else begin
            st_d.fsm = STE_IDLE;
          end
        end
      end
      STE_SRUN: begin
        if (!ssLow) begin
          st_d.fsm = STE_IDLE;
        end else if (edgeEv && edgeNum == STE_LAST_EDGE) begin
          complete = 1'b1;
          st_d.edgeCnt = 5'h00;
          if (clk_phase_sel) begin
            txLoad = !st_q.txEmpty;
          end else begin
            st_d.fsm = STE_SWAIT;
          end
        end
      end
      STE_SWAIT: begin
        if (!ssLow) begin
          st_d.fsm = STE_IDLE;
        end
      end
      default: begin
        st_d.fsm = STE_IDLE;
      end
    endcase

    // Shifter load from the transmit buffer.
    if (txLoad) begin
      st_d.txSh = st_q.txBuf;
      st_d.txEmpty = 1'b1;
    end

    // Receive buffer update; a read clearing the flag lets it in.
    if (complete && (!st_q.rxFull || rxClear)) begin
      // Take the bit sampled on the closing edge only if it samples.
      st_d.rxBuf = sampleEv ? rxNext : st_q.rxSh;
      st_d.rxFull = 1'b1;
    end else if (rxClear) begin
      st_d.rxFull = 1'b0;
    end

    // Mode fault overrides the master bit, fault flag and state set earlier in the cycle.
    if (master && st_q.ctrl2[STE_C2_MODE_FAULT_EN] &&
        !st_q.ctrl1[STE_C1_SEL_OUT_EN] && ssLow) begin
      st_d.mode_fault_flag = 1'b1;
      st_d.ctrl1[STE_C1_MASTER_SEL] = 1'b0;
      st_d.fsm = STE_IDLE;
    end

    // Read data is captured in the setup cycle.
    case (apbReq.paddr)
      STE_ADDR_CTRL1: rdVal = st_q.ctrl1;
      STE_ADDR_CTRL2: rdVal = st_q.ctrl2;
      STE_ADDR_DIV: rdVal = st_q.div;
      STE_ADDR_STATUS: begin
        rdVal[STE_ST_RXFULL] = st_q.rxFull;
        rdVal[STE_ST_TXEMPTY] = st_q.txEmpty;
        rdVal[STE_ST_MODE_FAULT_FLAG] = st_q.mode_fault_flag;
      end
      STE_ADDR_DATA: rdVal = st_q.rxBuf;
      default: hit = 1'b0;
    endcase
    if (apbReq.psel && !apbReq.penable) begin
      st_d.prdata = {24'h000000, rdVal};
      st_d.pslverr = ~hit;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
      st_q.fsm <= STE_IDLE;
      st_q.ctrl1 <= STE_CTRL1_RST;
      st_q.ctrl2 <= STE_CTRL2_RST;
      st_q.div <= STE_DIV_RST;
      st_q.txBuf <= STE_DATA_RST;
      st_q.rxBuf <= STE_DATA_RST;
      st_q.txEmpty <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Bus answer: zero wait states in the access phase.
  assign apbRsp.pready = apbReq.psel & apbReq.penable;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & st_q.pslverr;
  assign apbRsp.prdata = st_q.prdata;

  // Pin drive; leaving master mode releases clock and data.
  assign pinsOut.sclkOut = st_q.sclkLvl;
  assign pinsOut.sclkOe = master;
  assign pinsOut.mosiOut = txBit;
  assign pinsOut.mosiOe = master;
  assign pinsOut.misoOut = txBit;
  assign pinsOut.misoOe = ~master & ssLow & ~misoQuiet &
      (st_q.fsm == STE_SRUN || st_q.fsm == STE_SWAIT);
  assign pinsOut.ssNOut = ~(st_q.fsm == STE_LEAD || st_q.fsm == STE_RUN ||
                            st_q.fsm == STE_TRAIL);
  assign pinsOut.ssNOe = master & st_q.ctrl1[STE_C1_SEL_OUT_EN] &
      st_q.ctrl2[STE_C2_MODE_FAULT_EN];

  // Single shared interrupt request.
  assign irq = ((st_q.rxFull | st_q.mode_fault_flag) & st_q.ctrl1[STE_C1_RXIE]) |
      (st_q.txEmpty & st_q.ctrl1[STE_C1_TXIE]);

endmodule : ste_core

`default_nettype wire

// [design/ste_pkg.sv]
package ste_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB).
  // ==========================================================
  localparam logic [7:0] STE_ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] STE_ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] STE_ADDR_DIV = 8'h08;
  localparam logic [7:0] STE_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] STE_ADDR_DATA = 8'h10;

  // Control register one fields.
  localparam int STE_C1_RXIE = 7;
  localparam int STE_C1_TXIE = 5;
  localparam int STE_C1_MASTER_SEL = 4;
  localparam int STE_C1_CLK_POLARITY_SEL = 3;
  localparam int STE_C1_CLK_PHASE_SEL = 2;
  localparam int STE_C1_SEL_OUT_EN = 1;
  localparam int STE_C1_LSBF = 0;

  // Control register two fields.
  localparam int STE_C2_MODE_FAULT_EN = 4;
  localparam int STE_C2_BIDIR = 0;

  // Status register fields.
  localparam int STE_ST_RXFULL = 7;
  localparam int STE_ST_TXEMPTY = 5;
  localparam int STE_ST_MODE_FAULT_FLAG = 4;

  // Reset values.
  localparam logic [7:0] STE_CTRL1_RST = 8'h04;
  localparam logic [7:0] STE_CTRL2_RST = 8'h00;
  localparam logic [7:0] STE_DIV_RST = 8'h04;
  localparam logic [7:0] STE_DATA_RST = 8'h00;

  // One byte takes sixteen serial clock edges.
  localparam logic [4:0] STE_LAST_EDGE = 5'h10;
  localparam logic [4:0] STE_FIRST_EDGE = 5'h01;
  localparam logic [7:0] STE_MIN_HALF = 8'h01;
  localparam int STE_SYNC_W = 4;

  // Engine states.
  typedef enum logic [2:0] {
    STE_IDLE = 3'b000,
    STE_LEAD = 3'b001,
    STE_RUN = 3'b010,
    STE_TRAIL = 3'b011,
    STE_SRUN = 3'b100,
    STE_SWAIT = 3'b101
  } ste_state_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ste_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ste_apb_rsp_t;

  // Serial pin levels coming in.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ssN;
  } ste_pins_in_t;

  // Serial pin drive going out.
  typedef struct packed {
    logic sclkOut;
    logic sclkOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
    logic ssNOut;
    logic ssNOe;
  } ste_pins_out_t;

endpackage : ste_pkg

// [design/ste_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// Two flip-flop synchroniser for a group of pin levels.
module ste_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ste_sync_st_t;

  ste_sync_st_t st_q;
  ste_sync_st_t st_d;

  // The first stage feeds only the second stage.
  always_comb begin
    st_d.meta = asyncIn;
    st_d.stable = st_q.meta;
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.stable;

endmodule : ste_sync

`default_nettype wire

// [dv/ste_core_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// ========
// Link and bus checks on the engine ports.
module ste_core_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire ste_pkg::ste_apb_req_t apbReq,
  input wire ste_pkg::ste_apb_rsp_t apbRsp,
  input wire ste_pkg::ste_pins_in_t pinsIn,
  input wire ste_pkg::ste_pins_out_t pinsOut,
  input wire logic irq
);
  import ste_pkg::*;
  logic [5:0] edgeCnt_q;
  logic sclkOld_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Counts serial clock edges while select is held low.
  always_ff @(posedge clock) begin
    sclkOld_q <= pinsOut.sclkOut;
    if (rst || pinsOut.ssNOut) begin
      edgeCnt_q <= 6'h00;
    end else if (pinsOut.sclkOut != sclkOld_q) begin
      edgeCnt_q <= edgeCnt_q + 6'h01;
    end
  end
  // Select falls to open a frame and rises to close it.
  sequence ssLead;
    $fell(pinsOut.ssNOut) && pinsOut.ssNOe;
  endsequence
  sequence ssEnd;
    $rose(pinsOut.ssNOut) && pinsOut.ssNOe;
  endsequence
  AST_LEAD: assert property (ssLead |-> $stable(pinsOut.sclkOut))
    else $error("serial clock moved as select fell");
  AST_TRAIL: assert property ($changed(pinsOut.sclkOut) |-> not ssEnd)
    else $error("select rose with a clock edge");
  AST_EIGHT: assert property (ssEnd |-> edgeCnt_q[3:0] == 4'h0 && edgeCnt_q != 6'h00)
    else $error("frame edge count not a multiple of sixteen");
  AST_OE_PAIR: assert property (pinsOut.sclkOe == pinsOut.mosiOe)
    else $error("clock and data drivers disagree");
  AST_SLAVE_MISO: assert property (pinsOut.misoOe |-> !pinsOut.sclkOe)
    else $error("slave output driven while master");
  AST_SS_OUT: assert property (pinsOut.ssNOe |-> pinsOut.sclkOe)
    else $error("select driven outside master mode");
  AST_PREADY: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
    else $error("access cycle without ready");
  AST_PRDATA_HI: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_IRQ_RST: assert property ($fell(rst) |-> !irq)
    else $error("interrupt high after reset");
endmodule : ste_core_asserts

bind ste_core ste_core_asserts chk (.clock(clock), .rst(rst), .apbReq(apbReq),
  .apbRsp(apbRsp), .pinsIn(pinsIn), .pinsOut(pinsOut), .irq(irq));
`default_nettype wire

// [dv/ste_peer_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ========
// Serial slave peer facing the engine in master mode.
module ste_peer_model (
  input wire logic sclk,
  input wire logic ssN,
  input wire logic mosi,
  input wire logic clk_phase_sel,
  input wire logic lsbFirst,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  int edgeN;
  // Picks bit i of the byte in link order.
  function automatic logic pick(int i);
    return lsbFirst ? txByte[i] : txByte[7 - i];
  endfunction : pick
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
    edgeN = 0;
  end
  // Selection restarts the count; phase zero shows the first bit at once.
  always @(negedge ssN) begin
    edgeN = 0;
    miso = clk_phase_sel ? ~miso : pick(0);
  end
  // A released line keeps no stale level.
  always @(posedge ssN) begin
    miso = ~miso;
  end
  // Each clock edge samples or shifts, except the last edge in phase zero; phase one may chain.
  always @(sclk) begin
    if (ssN === 1'b0) begin
      edgeN = edgeN % 16 + 1;
      if (edgeN[0] != clk_phase_sel) begin
        rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      end else if (clk_phase_sel || edgeN < 16) begin
        miso = pick(edgeN / 2);
      end
    end
  end
endmodule : ste_peer_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ========
// Self-checking bench for the transfer engine.
module tb_top;
  import ste_pkg::*;
  logic clock, rst, irq, benchSsN, peerMiso, peerCpha, peerLsb, e;
  logic benchSclk, benchMosi;
  logic [7:0] peerTx, peerRx, v, tx, a, p;
  logic [31:0] w;
  int fails, checked, cyc;
  integer seed;
  ste_apb_req_t apbReq;
  ste_apb_rsp_t apbRsp;
  wire ste_pins_in_t pinsIn;
  ste_pins_out_t pinsOut;
  // Undriven clock and data rest low; select rests high.
  assign pinsIn.sclk = pinsOut.sclkOe ? pinsOut.sclkOut : benchSclk;
  assign pinsIn.mosi = pinsOut.mosiOe ? pinsOut.mosiOut : benchMosi;
  assign pinsIn.miso = pinsOut.misoOe ? pinsOut.misoOut : peerMiso;
  assign pinsIn.ssN = pinsOut.ssNOe ? pinsOut.ssNOut : benchSsN;
  ste_core uut (.clock(clock), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .pinsIn(pinsIn), .pinsOut(pinsOut), .irq(irq));
  ste_peer_model peer (.sclk(pinsIn.sclk), .ssN(pinsIn.ssN),
    .mosi(pinsIn.mosi), .clk_phase_sel(peerCpha), .lsbFirst(peerLsb),
    .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Cuts a hung run short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One bus transfer: setup, then access until ready.
  task automatic apb(logic wr, logic [7:0] ad, logic [7:0] d);
    int n;
    apbReq <= '{1'b1, 1'b0, wr, ad, {24'h0, d}};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n == 20) fails++;
    w = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic rd(logic [7:0] ad);
    apb(1'b0, ad, 8'h00);
    v = w[7:0];
  endtask : rd
  task automatic xfer(logic [7:0] d);
    rd(STE_ADDR_STATUS);
    apb(1'b1, STE_ADDR_DATA, d);
  endtask : xfer
  task automatic waitBit(int b);
    int n;
    n = 0;
    do begin
      rd(STE_ADDR_STATUS);
      n++;
    end while (v[b] !== 1'b1 && n < 100);
  endtask : waitBit
  task automatic waitEnd();
    int n;
    n = 0;
    while (pinsIn.ssN !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    while (pinsIn.ssN !== 1'b1 && n < 600) begin
      @(posedge clock);
      n++;
    end
  endtask : waitEnd
  function automatic logic [7:0] stat(logic full, logic emp, logic mode_fault_flag);
    return {full, 1'b0, emp, mode_fault_flag, 4'h0};
  endfunction : stat
  initial begin
    seed = 32'h701743A5;
    rst = 1'b1;
    apbReq = '0;
    benchSsN = 1'b1;
    benchSclk = 1'b0;
    benchMosi = 1'b0;
    peerTx = 8'h00;
    peerCpha = 1'b0;
    peerLsb = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(STE_ADDR_CTRL1);
    check("ctrl1", v, STE_CTRL1_RST);
    rd(STE_ADDR_CTRL2);
    check("ctrl2", v, STE_CTRL2_RST);
    rd(STE_ADDR_DIV);
    check("div", v, STE_DIV_RST);
    rd(STE_ADDR_DATA);
    check("data", v, STE_DATA_RST);
    apb(1'b1, 8'h14, 8'hFF);
    check("slverr", {7'h0, e}, 8'h01);
    apb(1'b1, STE_ADDR_CTRL2, 8'h10);
    apb(1'b1, STE_ADDR_CTRL1, 8'h16);
    apb(1'b1, STE_ADDR_DATA, 8'hA5);
    repeat (120) @(posedge clock);
    rd(STE_ADDR_STATUS);
    check("unarmed", v, stat(0, 1, 0));
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      tx = $random(seed);
      p = $random(seed);
      peerTx <= p;
      peerCpha <= m[1];
      peerLsb <= m[0];
      apb(1'b1, STE_ADDR_CTRL1, {3'b000, 1'b1, m[2], m[1], 1'b1, m[0]});
      xfer(tx);
      waitBit(STE_ST_RXFULL);
      check("full", v, stat(1, 1, 0));
      check("peer rx", peerRx, tx);
      rd(STE_ADDR_DATA);
      check("rx", v, p);
      rd(STE_ADDR_STATUS);
      check("rx clear", v, stat(0, 1, 0));
    end
    $display("test formats done");
    tx = $random(seed);
    xfer(tx);
    rd(STE_ADDR_STATUS);
    check("requeue", v, stat(0, 1, 0));
    a = $random(seed);
    apb(1'b1, STE_ADDR_DATA, a);
    rd(STE_ADDR_STATUS);
    check("queued", v, stat(0, 0, 0));
    waitBit(STE_ST_RXFULL);
    peerTx <= ~p;
    waitEnd();
    check("second", peerRx, a);
    rd(STE_ADDR_STATUS);
    check("overrun", v, stat(1, 1, 0));
    rd(STE_ADDR_DATA);
    check("kept", v, p);
    $display("test chain done");
    apb(1'b1, STE_ADDR_CTRL1, 8'h90);
    benchSsN <= 1'b0;
    waitBit(STE_ST_MODE_FAULT_FLAG);
    check("fault", v, stat(0, 1, 1));
    check("fault irq", {7'h0, irq}, 8'h01);
    check("sclk oe", {7'h0, pinsOut.sclkOe}, 8'h00);
    rd(STE_ADDR_CTRL1);
    check("master off", v, 8'h80);
    benchSsN <= 1'b1;
    rd(STE_ADDR_STATUS);
    apb(1'b1, STE_ADDR_CTRL1, 8'h00);
    rd(STE_ADDR_STATUS);
    check("fault clear", v, stat(0, 1, 0));
    apb(1'b1, STE_ADDR_CTRL1, 8'h20);
    check("tx irq", {7'h0, irq}, 8'h01);
    apb(1'b1, STE_ADDR_CTRL1, 8'h00);
    check("irq off", {7'h0, irq}, 8'h00);
    $display("test fault done");
    // Slave byte in phase zero: the bench acts as the link master.
    tx = $random(seed);
    a = $random(seed);
    xfer(tx);
    benchSsN <= 1'b0;
    repeat (5) @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      benchMosi <= a[i];
      repeat (5) @(posedge clock);
      p[i] = pinsIn.miso;
      benchSclk <= 1'b1;
      repeat (5) @(posedge clock);
      benchSclk <= 1'b0;
    end
    repeat (5) @(posedge clock);
    benchSsN <= 1'b1;
    check("slave miso", p, tx);
    rd(STE_ADDR_STATUS);
    check("slave full", v, stat(1, 1, 0));
    rd(STE_ADDR_DATA);
    check("slave rx", v, a);
    $display("test slave done");
    results();
  end
endmodule : tb_top
`default_nettype wire
